// file: bench/tcdp_host_model.sv
// Host side of the three-wire programming link
`timescale 1ns/1ps

module tcdp_host_model (
    // Programming link
    output logic prog_clk,
    output logic prog_serial_line,
    output logic prog_strobe
);
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    // Link clock stands high between frames
    initial begin
        prog_clk = 1'b1;
        prog_serial_line = 1'b0;
        prog_strobe = 1'b0;
    end

    // ----------------------------------------
    // Frame transfer
    // ----------------------------------------
    // Bits go out MSB first, one per falling edge, 15 ns link period
    task automatic send_frame(input logic [15:0] frame, input logic commit);
        for (int i = 15; i >= 0; i--) begin
            prog_serial_line = frame[i];
            #7.5 prog_clk = 1'b0;
            // Hold time spent, line no longer shows the bit
            #5 prog_serial_line = ~frame[i];
            #2.5 prog_clk = 1'b1;
        end
        if (commit) begin
            // Strobe well past last fall, long enough for clock syncs
            #5 prog_strobe = 1'b1;
            #50 prog_strobe = 1'b0;
        end
        #10;
    endtask : send_frame
endmodule : tcdp_host_model

// file: bench/transceiver_config_and_data_port_tb_top.sv
// Self-checking bench of the transceiver config port
`timescale 1ns/1ps

module transceiver_config_and_data_port_tb_top;
    import tcdp_pkg::*;

    logic clock = 1'b0;
    logic resetn = 1'b0;
    tcdp_bus_req_type bus_req = '0;
    logic [15:0] bus_rdata;
    logic prog_clk;
    logic prog_serial_line;
    logic prog_strobe;
    logic pin_level;
    logic host_pin_val = 1'b0;
    logic bidir_data_pin_out;
    logic bidir_data_pin_oe;
    logic fsk_demodulator_bit = 1'b0;
    logic pll_locked = 1'b0;
    logic fsk_mod_key;
    logic fsk_demodulator_precharge;
    logic reference_crystal_osc_run;
    logic power_amplifier_en;
    logic ext_if_filter_en;
    tcdp_cfg_type cfg;
    logic lock_out;
    logic [15:0] rd;
    int miscompares = 0;
    int cmp_count = 0;

    always #5 clock = ~clock;

    // Host drives the pin only while the device has let go
    assign pin_level = bidir_data_pin_oe ? bidir_data_pin_out : host_pin_val;

    tcdp_host_model i_host (
        .prog_clk(prog_clk),
        .prog_serial_line(prog_serial_line),
        .prog_strobe(prog_strobe)
    );

    tcdp_top i_dut (
        .clock(clock),
        .resetn(resetn),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .prog_clk(prog_clk),
        .prog_serial_line(prog_serial_line),
        .prog_strobe(prog_strobe),
        .bidir_data_pin_in(pin_level),
        .bidir_data_pin_out(bidir_data_pin_out),
        .bidir_data_pin_oe(bidir_data_pin_oe),
        .fsk_demodulator_bit(fsk_demodulator_bit),
        .pll_locked(pll_locked),
        .fsk_mod_key(fsk_mod_key),
        .fsk_demodulator_precharge(fsk_demodulator_precharge),
        .reference_crystal_osc_run(reference_crystal_osc_run),
        .power_amplifier_en(power_amplifier_en),
        .ext_if_filter_en(ext_if_filter_en),
        .cfg(cfg),
        .lock_out(lock_out)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock) bus_req <= '0;
    endtask : bus_write

    // Read data stands only in the cycle after the strobe
    task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock) bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock) bus_req <= '0;
        #1 d = bus_rdata;
    endtask : bus_read

    // Commit plus sync stages settle well within this
    task automatic frame(input logic [2:0] a, input logic [12:0] d, input logic commit);
        i_host.send_frame({a, d}, commit);
        repeat (8) @(posedge clock);
        // Step off the edge so registered outputs have settled
        #1;
    endtask : frame

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cycles

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    // Sixteen frames and a few hundred waits need well under 100 us
    initial begin
        #500000;
        miscompares++;
        finish_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        // Reset contents and unmapped places
        bus_read(4'h0, rd); check(rd, 16'h0800);
        bus_read(4'h8, rd); check(rd, 16'h0004);
        bus_write(4'h9, 16'hFFFF);
        bus_read(4'h9, rd); check(rd, 16'h0000);
        bus_read(4'hF, rd); check(rd, 16'h0000);
        bus_write(4'h6, 16'h0155);
        bus_read(4'h6, rd); check(rd, 16'h0155);
        end_test("reset_and_bus");
        // Synthesiser words and per-word isolation
        frame(3'd2, 13'h1ABC, 1'b1);
        frame(3'd3, 13'h0F0F, 1'b1);
        frame(3'd4, 13'h0123, 1'b1);
        frame(3'd5, 13'h1FFF, 1'b1);
        check(cfg.rf_freq, {13'h1ABC, 13'h0F0F});
        check(cfg.fsk_sep, 13'h0123);
        check(cfg.ref_div, 13'h1FFF);
        bus_read(4'h6, rd); check(rd, 16'h0155);
        bus_read(4'h0, rd); check(rd, 16'h0800);
        frame(3'd4, 13'h0456, 1'b0);
        check(cfg.fsk_sep, 13'h0123);
        end_test("synth_words");
        // Intermediate frequency choices
        for (int i = 0; i < 3; i++) begin
            frame(3'd1, {i[1:0], 11'h000}, 1'b1);
            check(cfg.if_sel, i[1:0]);
            check(ext_if_filter_en, i == 2);
        end
        end_test("if_select");
        // Transmit: pin is an input keying the modulator
        frame(3'd0, 13'h17AA, 1'b1);
        check({cfg.tx_mode, cfg.power_down, cfg.reference_crystal_osc_keep}, 3'b101);
        check({cfg.pa_class, cfg.pa_power, cfg.data_rate}, {2'b11, 4'hA, 3'h5});
        check({power_amplifier_en, bidir_data_pin_oe}, 2'b10);
        for (int v = 0; v < 2; v++) begin
            for (int k = 0; k < 2; k++) begin
                @(posedge clock) host_pin_val <= k[0];
                cycles(6);
                check(fsk_mod_key, k[0]);
            end
        end
        bus_read(4'h0, rd); check(rd, 16'h17AA);
        end_test("transmit");
        // Power amplifier classes
        for (int c = 0; c < 4; c++) begin
            bus_write(4'h0, {3'b000, 1'b1, 2'b00, c[1:0], 8'h00});
            cycles(2);
            check(cfg.pa_class, c[1:0]);
        end
        end_test("pa_class");
        // Receive with precharge: raw demodulator bits on the pin
        frame(3'd0, 13'h0001, 1'b1);
        check({bidir_data_pin_oe, power_amplifier_en}, 2'b10);
        check(fsk_demodulator_precharge, 1'b1);
        bus_read(4'h8, rd); check(rd, 16'h0008);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock) fsk_demodulator_bit <= k[0];
            cycles(6);
            check(pin_level, k[0]);
        end
        cycles(200);
        check(fsk_demodulator_precharge, 1'b0);
        end_test("receive");
        // Power-down keeps loaded words
        frame(3'd0, 13'h0800, 1'b1);
        check({bidir_data_pin_oe, reference_crystal_osc_run}, 2'b00);
        frame(3'd0, 13'h0C00, 1'b1);
        check(reference_crystal_osc_run, 1'b1);
        frame(3'd0, 13'h0000, 1'b1);
        check(bidir_data_pin_oe, 1'b1);
        check(cfg.rf_freq, {13'h1ABC, 13'h0F0F});
        check(cfg.ref_div, 13'h1FFF);
        end_test("power_down");
        // Lock indicator: continuous, disabled, monostable
        frame(3'd1, 13'h0400, 1'b1);
        @(posedge clock) pll_locked <= 1'b1;
        cycles(8);
        check(lock_out, 1'b1);
        bus_read(4'h8, rd); check(rd[0], 1'b1);
        @(posedge clock) pll_locked <= 1'b0;
        cycles(8);
        check(lock_out, 1'b0);
        @(posedge clock) pll_locked <= 1'b1;
        frame(3'd1, 13'h0000, 1'b1);
        check(lock_out, 1'b0);
        @(posedge clock) pll_locked <= 1'b0;
        frame(3'd1, 13'h0600, 1'b1);
        @(posedge clock) pll_locked <= 1'b1;
        cycles(10);
        check(lock_out, 1'b1);
        cycles(130);
        check(lock_out, 1'b0);
        end_test("lock");
        finish_test();
    end
endmodule : transceiver_config_and_data_port_tb_top

// file: design/tcdp_map.svh
// Offsets, field positions, reset values and timing counts of the config port
`ifndef TCDP_MAP_SVH
`define TCDP_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCDP_REG_CFG0 4'h0
`define TCDP_REG_CFG7 4'h7
`define TCDP_REG_STATUS 4'h8

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define TCDP_FRAME_W 16
`define TCDP_ADDR_HI 15
`define TCDP_ADDR_LO 13
`define TCDP_DATA_HI 12

// ----------------------------------------
// Word 0 and word 1 fields
// ----------------------------------------
`define TCDP_W0_TX 12
`define TCDP_W0_PD 11
`define TCDP_W0_XKEEP 10
`define TCDP_W0_PACLS_HI 9
`define TCDP_W0_PACLS_LO 8
`define TCDP_W0_PWR_HI 7
`define TCDP_W0_PWR_LO 4
`define TCDP_W0_RATE_HI 3
`define TCDP_W0_RATE_LO 1
`define TCDP_W0_PRECH 0
`define TCDP_W1_IF_HI 12
`define TCDP_W1_IF_LO 11
`define TCDP_W1_LKEN 10
`define TCDP_W1_LKMONO 9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCDP_CFG0_RST 13'h0800
`define TCDP_CFGN_RST 13'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define TCDP_CLK_MHZ 100
`define TCDP_PRECHARGE_NS 2000
`define TCDP_PRECHARGE_CYC ((`TCDP_PRECHARGE_NS * `TCDP_CLK_MHZ + 999) / 1000)
`define TCDP_LOCK_PULSE_NS 1000
`define TCDP_LOCK_PULSE_CYC ((`TCDP_LOCK_PULSE_NS * `TCDP_CLK_MHZ) / 1000)

`endif

// file: design/tcdp_pkg.sv
// Types shared by the transceiver config port
package tcdp_pkg;
    typedef logic [12:0] tcdp_word_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tcdp_bus_req_type;

    typedef enum logic [1:0] {
        TCDP_IF_60 = 2'b00,
        TCDP_IF_200 = 2'b01,
        TCDP_IF_455 = 2'b10
    } tcdp_if_type;

    typedef enum logic [1:0] {
        TCDP_LK_OFF = 2'b00,
        TCDP_LK_WAIT = 2'b01,
        TCDP_LK_PULSE = 2'b10,
        TCDP_LK_CONT = 2'b11
    } tcdp_lock_state_type;

    typedef struct packed {
        logic tx_mode;
        logic power_down;
        logic reference_crystal_osc_keep;
        logic [1:0] pa_class;
        logic [3:0] pa_power;
        logic [2:0] data_rate;
        logic precharge_en;
        logic [1:0] if_sel;
        logic lock_en;
        logic lock_mono;
        logic [25:0] rf_freq;
        logic [12:0] fsk_sep;
        logic [12:0] ref_div;
    } tcdp_cfg_type;
endpackage : tcdp_pkg

// file: design/tcdp_top.sv
// Serial configuration bank and data pin logic of the FSK transceiver
// Operation
// - In transmit the data pin is an input carrying the bits to send.
// - In receive the data pin is driven with the demodulator result.
// - In continuous lock mode, lock output is high while the synthesiser is locked, else low.
// - Config arrives on programming clock, serial line and load strobe.
// - Receive bits go out raw; host recovers timing and decides values.
// - Transmit keys the modulator from the current data pin level.
// - Config selects rx/tx, power-down, output power and data rate.
// - Config holds RF frequency, FSK separation and reference divider.
// - A setting keeps the crystal oscillator running in power-down.
// - IF picks 60, 200 or 455 kHz; only 455 uses external filter.
// - Lock detect can be off, monostable or continuous.
// - Config selects amplifier class A, AB, B or C.
// - Receive mode offers a demodulator precharge to settle faster.
// - Frames are sixteen bits, MSB first, top three bits address.
// - One serial bit is captured on each programming clock fall.
// - The strobe pulse after sixteen bits commits the frame.
// - Loaded config survives power-down; only changed frames resent.
`timescale 1ns/1ps
`include "tcdp_map.svh"

module tcdp_top
    import tcdp_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire tcdp_bus_req_type bus_req,
    output logic [15:0] bus_rdata,
    // Serial programming link
    input wire logic prog_clk,
    input wire logic prog_serial_line,
    input wire logic prog_strobe,
    // Bidirectional data pin
    input wire logic bidir_data_pin_in,
    output logic bidir_data_pin_out,
    output logic bidir_data_pin_oe,
    // Analog side
    input wire logic fsk_demodulator_bit,
    input wire logic pll_locked,
    output logic fsk_mod_key,
    output logic fsk_demodulator_precharge,
    output logic reference_crystal_osc_run,
    output logic power_amplifier_en,
    output logic ext_if_filter_en,
    output tcdp_cfg_type cfg,
    // Status
    output logic lock_out
);

// ----------------------------------------
// Link domain shift register
// ----------------------------------------
logic [15:0] shift_r;

always_ff @(negedge prog_clk or negedge resetn) begin
    if (!resetn) begin
        shift_r <= 16'h0000;
    end else begin
        shift_r <= {shift_r[14:0], prog_serial_line};
    end
end

chk_shift_msb_first: assert property (@(negedge prog_clk) disable iff (!resetn)
    shift_r[15] == $past(prog_serial_line, 16))
    else $error("serial bit order wrong");

// ----------------------------------------
// Strobe crossing
// ----------------------------------------
logic strobe_s1_r;
logic strobe_s2_r;
logic strobe_s3_r;
logic commit;

// Shift word is frozen while strobe is high, so strobe qualifies the word
always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        strobe_s1_r <= 1'b0;
        strobe_s2_r <= 1'b0;
        strobe_s3_r <= 1'b0;
    end else begin
        strobe_s1_r <= prog_strobe;
        strobe_s2_r <= strobe_s1_r;
        strobe_s3_r <= strobe_s2_r;
    end
end

assign commit = strobe_s2_r & ~strobe_s3_r;

// ----------------------------------------
// Configuration bank
// ----------------------------------------
logic [7:0][12:0] cfg_r;
logic [7:0][12:0] cfg_nxt;
logic bus_cfg_wr;

assign bus_cfg_wr = bus_req.wr & (bus_req.addr <= `TCDP_REG_CFG7);

function automatic logic [7:0] sel_onehot(input logic [2:0] a);
    sel_onehot = 8'h01 << a;
endfunction : sel_onehot

// Serial commit wins over a bus write to the same word
always_comb begin
    cfg_nxt = cfg_r;
    for (int i = 0; i < 8; i++) begin
        if (commit && sel_onehot(shift_r[`TCDP_ADDR_HI:`TCDP_ADDR_LO])[i]) begin
            cfg_nxt[i] = shift_r[`TCDP_DATA_HI:0];
        end else if (bus_cfg_wr && sel_onehot(bus_req.addr[2:0])[i]) begin
            cfg_nxt[i] = bus_req.wdata[12:0];
        end
    end
end

// No power-down path touches the bank, so words persist
always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        cfg_r[0] <= `TCDP_CFG0_RST;
        for (int i = 1; i < 8; i++) begin
            cfg_r[i] <= `TCDP_CFGN_RST;
        end
    end else begin
        cfg_r <= cfg_nxt;
    end
end

chk_commit_word: assert property (@(posedge clock) disable iff (!resetn)
    commit |=> cfg_r[$past(shift_r[15:13])] == $past(shift_r[12:0]))
    else $error("committed word not stored");

chk_other_keep: assert property (@(posedge clock) disable iff (!resetn)
    commit && shift_r[15:13] != 3'h5 && !(bus_cfg_wr && bus_req.addr[2:0] == 3'h5)
    |=> $stable(cfg_r[5]))
    else $error("unaddressed word changed");

chk_no_strobe_keep: assert property (@(posedge clock) disable iff (!resetn)
    !commit && !bus_cfg_wr |=> $stable(cfg_r))
    else $error("config changed without strobe");

// ----------------------------------------
// Field decode
// ----------------------------------------
always_comb begin
    cfg.tx_mode = cfg_r[0][`TCDP_W0_TX];
    cfg.power_down = cfg_r[0][`TCDP_W0_PD];
    cfg.reference_crystal_osc_keep = cfg_r[0][`TCDP_W0_XKEEP];
    cfg.pa_class = cfg_r[0][`TCDP_W0_PACLS_HI:`TCDP_W0_PACLS_LO];
    cfg.pa_power = cfg_r[0][`TCDP_W0_PWR_HI:`TCDP_W0_PWR_LO];
    cfg.data_rate = cfg_r[0][`TCDP_W0_RATE_HI:`TCDP_W0_RATE_LO];
    cfg.precharge_en = cfg_r[0][`TCDP_W0_PRECH];
    cfg.if_sel = cfg_r[1][`TCDP_W1_IF_HI:`TCDP_W1_IF_LO];
    cfg.lock_en = cfg_r[1][`TCDP_W1_LKEN];
    cfg.lock_mono = cfg_r[1][`TCDP_W1_LKMONO];
    cfg.rf_freq = {cfg_r[2], cfg_r[3]};
    cfg.fsk_sep = cfg_r[4];
    cfg.ref_div = cfg_r[5];
end

logic rx_active;
logic tx_active;

assign rx_active = ~cfg.tx_mode & ~cfg.power_down;
assign tx_active = cfg.tx_mode & ~cfg.power_down;

// ----------------------------------------
// Power control
// ----------------------------------------
logic reference_crystal_osc_run_r;
logic pa_en_r;
logic ext_if_r;

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        reference_crystal_osc_run_r <= 1'b0;
        pa_en_r <= 1'b0;
        ext_if_r <= 1'b0;
    end else begin
        reference_crystal_osc_run_r <= ~cfg.power_down | cfg.reference_crystal_osc_keep;
        pa_en_r <= tx_active;
        // Unused IF code falls back to on-chip filtering
        ext_if_r <= (cfg.if_sel == TCDP_IF_455);
    end
end

assign reference_crystal_osc_run = reference_crystal_osc_run_r;
assign power_amplifier_en = pa_en_r;
assign ext_if_filter_en = ext_if_r;

chk_reference_crystal_osc_keep: assert property (@(posedge clock) disable iff (!resetn)
    cfg.power_down && cfg.reference_crystal_osc_keep ##1 cfg.power_down && cfg.reference_crystal_osc_keep |-> reference_crystal_osc_run)
    else $error("oscillator stopped despite keep setting");

chk_ext_if: assert property (@(posedge clock) disable iff (!resetn)
    ##1 ext_if_filter_en == ($past(cfg.if_sel) == TCDP_IF_455))
    else $error("external IF filter select wrong");

// ----------------------------------------
// Data pin
// ----------------------------------------
logic din_s1_r;
logic din_s2_r;
logic dem_s1_r;
logic dem_s2_r;
logic pin_out_r;
logic key_r;

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        din_s1_r <= 1'b0;
        din_s2_r <= 1'b0;
        dem_s1_r <= 1'b0;
        dem_s2_r <= 1'b0;
    end else begin
        din_s1_r <= bidir_data_pin_in;
        din_s2_r <= din_s1_r;
        dem_s1_r <= fsk_demodulator_bit;
        dem_s2_r <= dem_s1_r;
    end
end

// Bits pass raw; no slicing or retiming, the host decides each bit
always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        pin_out_r <= 1'b0;
        key_r <= 1'b0;
    end else begin
        pin_out_r <= rx_active & dem_s2_r;
        key_r <= tx_active & din_s2_r;
    end
end

assign bidir_data_pin_out = pin_out_r;
assign bidir_data_pin_oe = rx_active;
assign fsk_mod_key = key_r;

sequence rx_held;
    rx_active [*4];
endsequence

sequence tx_held;
    tx_active [*4];
endsequence

chk_tx_pin_input: assert property (@(posedge clock) disable iff (!resetn)
    tx_active |-> !bidir_data_pin_oe)
    else $error("data pin driven in transmit");

chk_rx_pin_drive: assert property (@(posedge clock) disable iff (!resetn)
    rx_held |-> bidir_data_pin_oe && bidir_data_pin_out == $past(fsk_demodulator_bit, 3))
    else $error("receive data not on pin");

chk_tx_keying: assert property (@(posedge clock) disable iff (!resetn)
    tx_held |-> fsk_mod_key == $past(bidir_data_pin_in, 3))
    else $error("modulator key does not follow pin");

// ----------------------------------------
// Lock indicator
// ----------------------------------------
localparam logic [7:0] LOCK_PULSE_CYC = 8'(`TCDP_LOCK_PULSE_CYC);

logic lock_s1_r;
logic lock_s2_r;
logic lock_s3_r;
tcdp_lock_state_type lk_state_r;
tcdp_lock_state_type lk_state_nxt;
logic [7:0] lk_cnt_r;
logic lock_out_r;

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        lock_s1_r <= 1'b0;
        lock_s2_r <= 1'b0;
        lock_s3_r <= 1'b0;
    end else begin
        lock_s1_r <= pll_locked;
        lock_s2_r <= lock_s1_r;
        lock_s3_r <= lock_s2_r;
    end
end

always_comb begin
    lk_state_nxt = lk_state_r;
    unique case (lk_state_r)
        TCDP_LK_OFF: begin
            if (cfg.lock_en) begin
                lk_state_nxt = cfg.lock_mono ? TCDP_LK_WAIT : TCDP_LK_CONT;
            end
        end
        TCDP_LK_WAIT: begin
            if (!cfg.lock_en || !cfg.lock_mono) begin
                lk_state_nxt = TCDP_LK_OFF;
            end else if (lock_s2_r && !lock_s3_r) begin
                lk_state_nxt = TCDP_LK_PULSE;
            end
        end
        TCDP_LK_PULSE: begin
            if (!cfg.lock_en || !cfg.lock_mono) begin
                lk_state_nxt = TCDP_LK_OFF;
            end else if (!lock_s2_r || lk_cnt_r == 8'h01) begin
                lk_state_nxt = TCDP_LK_WAIT;
            end
        end
        TCDP_LK_CONT: begin
            if (!cfg.lock_en || cfg.lock_mono) begin
                lk_state_nxt = TCDP_LK_OFF;
            end
        end
    endcase
end

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        lk_state_r <= TCDP_LK_OFF;
    end else begin
        lk_state_r <= lk_state_nxt;
    end
end

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        lk_cnt_r <= 8'h00;
    end else if (lk_state_r == TCDP_LK_WAIT) begin
        lk_cnt_r <= LOCK_PULSE_CYC;
    end else if (lk_cnt_r != 8'h00) begin
        lk_cnt_r <= lk_cnt_r - 8'h01;
    end
end

// Monostable reports a lock only for a while; output never high when unlocked
always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        lock_out_r <= 1'b0;
    end else begin
        lock_out_r <= lock_s2_r & ((lk_state_r == TCDP_LK_CONT) | (lk_state_r == TCDP_LK_PULSE));
    end
end

assign lock_out = lock_out_r;

chk_lock_low: assert property (@(posedge clock) disable iff (!resetn)
    !lock_s2_r |=> !lock_out)
    else $error("lock shown while unlocked");

chk_lock_cont: assert property (@(posedge clock) disable iff (!resetn)
    lk_state_r == TCDP_LK_CONT && cfg.lock_en && !cfg.lock_mono |=> lock_out == $past(lock_s2_r))
    else $error("continuous lock not followed");

// ----------------------------------------
// Demodulator precharge
// ----------------------------------------
localparam logic [7:0] PRECHARGE_CYC = 8'(`TCDP_PRECHARGE_CYC);

logic w0_written;
logic [7:0] prech_cnt_r;

assign w0_written = |(cfg_r[0] ^ cfg_nxt[0]);

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        prech_cnt_r <= 8'h00;
    end else if (w0_written && !cfg_nxt[0][`TCDP_W0_TX] && !cfg_nxt[0][`TCDP_W0_PD]
                 && cfg_nxt[0][`TCDP_W0_PRECH]) begin
        prech_cnt_r <= PRECHARGE_CYC;
    end else if (!rx_active) begin
        prech_cnt_r <= 8'h00;
    end else if (prech_cnt_r != 8'h00) begin
        prech_cnt_r <= prech_cnt_r - 8'h01;
    end
end

assign fsk_demodulator_precharge = (prech_cnt_r != 8'h00);

chk_precharge_rx: assert property (@(posedge clock) disable iff (!resetn)
    fsk_demodulator_precharge |-> rx_active)
    else $error("precharge outside receive");

// ----------------------------------------
// Register read port
// ----------------------------------------
logic [15:0] rdata_r;

always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        rdata_r <= 16'h0000;
    end else if (bus_req.rd) begin
        if (bus_req.addr <= `TCDP_REG_CFG7) begin
            rdata_r <= {3'h0, cfg_r[bus_req.addr[2:0]]};
        end else if (bus_req.addr == `TCDP_REG_STATUS) begin
            rdata_r <= {12'h000, fsk_demodulator_precharge, cfg.power_down, cfg.tx_mode, lock_out_r};
        end else begin
            rdata_r <= 16'h0000;
        end
    end else begin
        rdata_r <= 16'h0000;
    end
end

assign bus_rdata = rdata_r;

chk_read_cfg: assert property (@(posedge clock) disable iff (!resetn)
    bus_req.rd && bus_req.addr == `TCDP_REG_CFG0 |=> bus_rdata == {3'h0, $past(cfg_r[0])})
    else $error("config read wrong");

endmodule : tcdp_top
